// file: pkg/amp_diag_pkg.sv
`default_nettype none
package amp_diag_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_PHASE_HIGH = 8'h1B;
    localparam logic [7:0] ADDR_PHASE_LOW = 8'h1C;
    localparam logic [7:0] ADDR_SETTLE_HIGH = 8'h1D;
    localparam logic [7:0] ADDR_SETTLE_LOW = 8'h1E;
    localparam logic [7:0] ADDR_FAULT_CTRL = 8'h21;
    localparam logic [7:0] ADDR_CLIP_CTRL = 8'h22;
    localparam logic [7:0] ADDR_CLIP_WINDOW = 8'h23;
    localparam logic [7:0] ADDR_CLIP_FLAGS = 8'h24;
    localparam logic [7:0] ADDR_CURRENT_LIMIT_EVENT_FLAGS = 8'h25;

    // Field positions
    localparam int unsigned BIT_CLEAR_FAULT = 7;
    localparam int unsigned BIT_SOURCE_FLIP = 6;
    localparam int unsigned BIT_WARN_SUPPRESS = 5;
    localparam int unsigned BIT_AUTO_RECOVER = 3;
    localparam int unsigned BIT_CLIP_ENABLE = 0;

    // Reset values
    localparam logic [15:0] RST_RESULT = 16'h0000;
    localparam logic RST_SOURCE_FLIP = 1'b0;
    localparam logic RST_WARN_SUPPRESS = 1'b0;
    localparam logic RST_AUTO_RECOVER = 1'b0;
    localparam logic RST_CLIP_ENABLE = 1'b1;
    localparam logic [7:0] RST_CLIP_WINDOW = 8'h14;
    localparam logic [7:0] RST_FLAGS = 8'h00;

    // Serial target; the address value is arbitrary
    localparam logic [6:0] DEFAULT_TARGET_ADDR = 7'h2A;
    localparam int unsigned NUM_CHANNELS = 4;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX = 5'h02,
        ST_ACK = 5'h04,
        ST_TX = 5'h08,
        ST_MACK = 5'h10
    } target_state_e;

    typedef enum logic [2:0] {
        PH_ADDR = 3'h1,
        PH_PTR = 3'h2,
        PH_DATA = 3'h4
    } byte_phase_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } reg_write_s;

    typedef struct packed {
        logic [15:0] phase;
        logic [15:0] settle;
    } diag_result_s;

endpackage : amp_diag_pkg
`default_nettype wire

// file: rtl/serial_target.sv
`timescale 1ns/1ps
`default_nettype none
module serial_target
    import amp_diag_pkg::*;
#(
    parameter logic [6:0] TARGET_ADDR = DEFAULT_TARGET_ADDR
)(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Bus pins
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    // Register side
    output logic [7:0] o_pointer,
    output logic o_wr_en,
    output reg_write_s o_wr,
    input wire logic [7:0] i_rd_data
);

    logic [1:0] scl_sync, sda_sync;
    logic scl_d, sda_d, scl_rise, scl_fall, start_seen, stop_seen;
    target_state_e state, next_state;
    byte_phase_e phase, next_phase;
    logic read_mode, next_read_mode, sda_oe, next_sda_oe, wr_en, next_wr_en;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] shift, next_shift, pointer, next_pointer;
    reg_write_s wr, next_wr;

    // Edges are taken from the second stage only
    assign scl_rise = scl_sync[1] & ~scl_d;
    assign scl_fall = ~scl_sync[1] & scl_d;
    assign start_seen = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
    assign stop_seen = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];

    always_comb
    begin
        next_state = state;
        next_phase = phase;
        next_read_mode = read_mode;
        next_bit_cnt = bit_cnt;
        next_shift = shift;
        next_pointer = pointer;
        next_sda_oe = sda_oe;
        next_wr_en = 1'b0;
        next_wr = wr;
        if (start_seen)
        begin
            // Repeated start keeps the pointer for a following read
            next_state = ST_RX;
            next_phase = PH_ADDR;
            next_bit_cnt = 4'h0;
            next_sda_oe = 1'b0;
        end
        else if (stop_seen)
        begin
            next_state = ST_IDLE;
            next_sda_oe = 1'b0;
        end
        else
        begin
            case (state)
                ST_RX:
                begin
                    if (scl_rise)
                    begin
                        next_shift = {shift[6:0], sda_sync[1]};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end
                    else if (scl_fall && bit_cnt == BITS_PER_BYTE)
                    begin
                        next_sda_oe = 1'b1;
                        next_state = ST_ACK;
                        case (phase)
                            PH_ADDR:
                            begin
                                next_read_mode = shift[0];
                                next_phase = PH_PTR;
                                if (shift[7:1] != TARGET_ADDR)
                                begin
                                    next_sda_oe = 1'b0;
                                    next_state = ST_IDLE;
                                end
                            end
                            PH_PTR:
                            begin
                                next_pointer = shift;
                                next_phase = PH_DATA;
                            end
                            default:
                            begin
                                next_wr_en = 1'b1;
                                next_wr = '{addr: pointer, data: shift};
                                next_pointer = pointer + 8'h01;
                            end
                        endcase
                    end
                end
                ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        next_bit_cnt = 4'h0;
                        if (read_mode)
                        begin
                            next_shift = i_rd_data;
                            next_sda_oe = ~i_rd_data[7];
                            next_state = ST_TX;
                        end
                        else
                        begin
                            next_sda_oe = 1'b0;
                            next_state = ST_RX;
                        end
                    end
                end
                ST_TX:
                begin
                    if (scl_fall)
                    begin
                        next_bit_cnt = bit_cnt + 4'h1;
                        if (bit_cnt == LAST_TX_BIT)
                        begin
                            next_sda_oe = 1'b0;
                            next_state = ST_MACK;
                        end
                        else
                        begin
                            next_shift = {shift[6:0], 1'b0};
                            next_sda_oe = ~shift[6];
                        end
                    end
                end
                ST_MACK:
                begin
                    if (scl_rise)
                    begin
                        if (sda_sync[1])
                            next_state = ST_IDLE;
                        else
                            next_pointer = pointer + 8'h01;
                    end
                    else if (scl_fall)
                    begin
                        // Pointer moved on the rising edge, so read data is already current
                        next_shift = i_rd_data;
                        next_sda_oe = ~i_rd_data[7];
                        next_bit_cnt = 4'h0;
                        next_state = ST_TX;
                    end
                end
                default:
                begin
                    next_state = ST_IDLE;
                    next_sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            state <= ST_IDLE;
            phase <= PH_ADDR;
            read_mode <= 1'b0;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            pointer <= 8'h00;
            sda_oe <= 1'b0;
            wr_en <= 1'b0;
            wr <= '0;
        end
        else
        begin
            scl_sync <= {scl_sync[0], i_scl};
            sda_sync <= {sda_sync[0], i_sda};
            scl_d <= scl_sync[1];
            sda_d <= sda_sync[1];
            state <= next_state;
            phase <= next_phase;
            read_mode <= next_read_mode;
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
            pointer <= next_pointer;
            sda_oe <= next_sda_oe;
            wr_en <= next_wr_en;
            wr <= next_wr;
        end
    end

    // Open-drain: the pin is only ever pulled low
    assign o_sda_out = 1'b0;
    assign o_sda_oe = sda_oe;
    assign o_pointer = pointer;
    assign o_wr_en = wr_en;
    assign o_wr = wr;

endmodule : serial_target
`default_nettype wire

// file: rtl/amp_diag_clip_fault_regs.sv
// Operation
// - Register 0x1B reads phase result bits 15:8, read-only, resets to zero.
// - Register 0x1C reads phase result bits 7:0, read-only, resets to zero.
// - Register 0x1D reads settling-time result bits 15:8, read-only, resets to zero.
// - Settling-time result bits 7:0 readable in own read-only register, resets to zero.
// - Writing one to control bit 7 clears latched faults; zero is normal.
// - Control bit 6 selects normal or flipped source for parallel-bridge pairs.
// - Control bit 5 low reports current-limit on warn pin; high suppresses.
// - Control bit 3 high auto-recovers overtemperature and hides it from fault pin.
// - Clip control bit 0 enables clip detection; resets set.
// - Clip window is an 8-bit read/write register resetting to 0x14.
// - Clip register bits 3:0 flag clipping per channel; upper bits zero.
// - Current-limit status register sits at 0x25, read-only, resets zero.
// - Current-limit bits 3:0 flag warnings per channel; upper bits zero.
`timescale 1ns/1ps
`default_nettype none
module amp_diag_clip_fault_regs
    import amp_diag_pkg::*;
#(
    parameter int unsigned NUM_CH = NUM_CHANNELS,
    parameter logic [6:0] TARGET_ADDR = DEFAULT_TARGET_ADDR
)(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Serial control pins
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    // Load diagnostic results
    input wire logic i_diag_done,
    input wire diag_result_s i_diag_result,
    // Channel and protection events
    input wire logic [NUM_CH-1:0] i_clip_detect,
    input wire logic [NUM_CH-1:0] i_current_limit_event,
    input wire logic i_overtemp_shutdown,
    // Controls to the amplifier core
    output logic o_clear_fault,
    output logic o_parallel_bridge_source_flip,
    output logic o_overtemp_auto_recover,
    output logic o_clip_detect_enable,
    output logic [7:0] o_clip_window_select,
    // Report pins
    output logic o_fault_n,
    output logic o_warn_n
);

    generate
        if (NUM_CH < 1 || NUM_CH > 4)
        begin : g_bad_channels
            $error("NUM_CH must be 1 to 4");
        end
    endgenerate

    logic [7:0] pointer, rd_data;
    logic wr_en, ctrl_write, clip_ctrl_write, window_write;
    reg_write_s wr;
    logic [15:0] phase_result, next_phase_result, settle_result, next_settle_result;
    logic clear_fault, next_clear_fault, source_flip, next_source_flip, warn_suppress, next_warn_suppress;
    logic auto_recover, next_auto_recover, clip_enable, next_clip_enable, overtemp_latched, next_overtemp_latched;
    logic fault_n, next_fault_n, warn_n, next_warn_n;
    logic [7:0] clip_window, next_clip_window;
    logic [NUM_CH-1:0] clip_flags, next_clip_flags, current_limit_event_flags, next_current_limit_event_flags;

    serial_target #(
        .TARGET_ADDR(TARGET_ADDR)
    ) u_target (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .o_sda_out(o_sda_out),
        .o_sda_oe(o_sda_oe),
        .o_pointer(pointer),
        .o_wr_en(wr_en),
        .o_wr(wr),
        .i_rd_data(rd_data)
    );

    // Result and flag offsets have no write path
    assign ctrl_write = wr_en && (wr.addr == ADDR_FAULT_CTRL);
    assign clip_ctrl_write = wr_en && (wr.addr == ADDR_CLIP_CTRL);
    assign window_write = wr_en && (wr.addr == ADDR_CLIP_WINDOW);

    always_comb
    begin
        rd_data = 8'h00;
        case (pointer)
            ADDR_PHASE_HIGH: rd_data = phase_result[15:8];
            ADDR_PHASE_LOW: rd_data = phase_result[7:0];
            ADDR_SETTLE_HIGH: rd_data = settle_result[15:8];
            ADDR_SETTLE_LOW: rd_data = settle_result[7:0];
            ADDR_FAULT_CTRL:
            begin
                rd_data[BIT_SOURCE_FLIP] = source_flip;
                rd_data[BIT_WARN_SUPPRESS] = warn_suppress;
                rd_data[BIT_AUTO_RECOVER] = auto_recover;
            end
            ADDR_CLIP_CTRL: rd_data[BIT_CLIP_ENABLE] = clip_enable;
            ADDR_CLIP_WINDOW: rd_data = clip_window;
            ADDR_CLIP_FLAGS: rd_data = {{(8-NUM_CH){1'b0}}, clip_flags};
            ADDR_CURRENT_LIMIT_EVENT_FLAGS: rd_data = {{(8-NUM_CH){1'b0}}, current_limit_event_flags};
            default: rd_data = 8'h00;
        endcase
    end

    // Results load only when a measurement completes; a load between the two byte reads mixes two samples
    always_comb
    begin
        next_phase_result = phase_result;
        next_settle_result = settle_result;
        if (i_diag_done)
        begin
            next_phase_result = i_diag_result.phase;
            next_settle_result = i_diag_result.settle;
        end
    end

    always_comb
    begin
        next_source_flip = source_flip;
        next_warn_suppress = warn_suppress;
        next_auto_recover = auto_recover;
        next_clip_enable = clip_enable;
        next_clip_window = clip_window;
        // Clear is a one-cycle action; the bit never holds so faults can latch again
        next_clear_fault = ctrl_write && wr.data[BIT_CLEAR_FAULT];
        if (ctrl_write)
        begin
            next_source_flip = wr.data[BIT_SOURCE_FLIP];
            next_warn_suppress = wr.data[BIT_WARN_SUPPRESS];
            next_auto_recover = wr.data[BIT_AUTO_RECOVER];
        end
        if (clip_ctrl_write)
            next_clip_enable = wr.data[BIT_CLIP_ENABLE];
        if (window_write)
            next_clip_window = wr.data;
    end

    // A new event in the clearing cycle survives the clear
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++)
        begin : g_channel
            assign next_clip_flags[ch] = (i_clip_detect[ch] & clip_enable)
                | (clip_flags[ch] & ~clear_fault);
            assign next_current_limit_event_flags[ch] = i_current_limit_event[ch]
                | (current_limit_event_flags[ch] & ~clear_fault);
        end
    endgenerate

    always_comb
    begin
        // With auto-recovery the condition is never latched, so it clears itself
        next_overtemp_latched = (i_overtemp_shutdown & ~auto_recover)
            | (overtemp_latched & ~clear_fault & ~auto_recover);
        next_fault_n = ~overtemp_latched;
        next_warn_n = ~((|current_limit_event_flags & ~warn_suppress) | (|clip_flags));
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            phase_result <= RST_RESULT;
            settle_result <= RST_RESULT;
            clear_fault <= 1'b0;
            source_flip <= RST_SOURCE_FLIP;
            warn_suppress <= RST_WARN_SUPPRESS;
            auto_recover <= RST_AUTO_RECOVER;
            clip_enable <= RST_CLIP_ENABLE;
            clip_window <= RST_CLIP_WINDOW;
            clip_flags <= RST_FLAGS[NUM_CH-1:0];
            current_limit_event_flags <= RST_FLAGS[NUM_CH-1:0];
            overtemp_latched <= 1'b0;
            fault_n <= 1'b1;
            warn_n <= 1'b1;
        end
        else
        begin
            phase_result <= next_phase_result;
            settle_result <= next_settle_result;
            clear_fault <= next_clear_fault;
            source_flip <= next_source_flip;
            warn_suppress <= next_warn_suppress;
            auto_recover <= next_auto_recover;
            clip_enable <= next_clip_enable;
            clip_window <= next_clip_window;
            clip_flags <= next_clip_flags;
            current_limit_event_flags <= next_current_limit_event_flags;
            overtemp_latched <= next_overtemp_latched;
            fault_n <= next_fault_n;
            warn_n <= next_warn_n;
        end
    end

    assign o_clear_fault = clear_fault;
    assign o_parallel_bridge_source_flip = source_flip;
    assign o_overtemp_auto_recover = auto_recover;
    assign o_clip_detect_enable = clip_enable;
    assign o_clip_window_select = clip_window;
    assign o_fault_n = fault_n;
    assign o_warn_n = warn_n;

endmodule : amp_diag_clip_fault_regs
`default_nettype wire

// file: testbench/amp_diag_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module amp_diag_regs_checker
    import amp_diag_pkg::*;
#(
    parameter int unsigned NUM_CH = NUM_CHANNELS
)(
    // Clock, reset, bus clock and data enable
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic o_sda_oe,
    // Events
    input wire logic [NUM_CH-1:0] i_clip_detect,
    input wire logic [NUM_CH-1:0] i_current_limit_event,
    input wire logic i_overtemp_shutdown,
    // Controls and pins
    input wire logic o_clear_fault,
    input wire logic o_parallel_bridge_source_flip,
    input wire logic o_overtemp_auto_recover,
    input wire logic o_clip_detect_enable,
    input wire logic [7:0] o_clip_window_select,
    input wire logic o_fault_n,
    input wire logic o_warn_n
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_quiet;
        !(|i_clip_detect) && !(|i_current_limit_event);
    endsequence
    sequence s_quiet_clear;
        o_clear_fault ##0 s_quiet ##1 s_quiet;
    endsequence

    property p_clear_pulse;
        $rose(o_clear_fault) |=> !o_clear_fault;
    endproperty
    property p_clear_drops_warn;
        s_quiet_clear |-> ##[1:2] o_warn_n;
    endproperty
    property p_clip_warn;
        (o_clip_detect_enable && (|i_clip_detect)) |-> ##[1:3] !o_warn_n;
    endproperty
    property p_overtemp_fault;
        (!o_overtemp_auto_recover && i_overtemp_shutdown) |-> ##[1:3] !o_fault_n;
    endproperty
    property p_auto_recover_quiet;
        o_overtemp_auto_recover [*5] |-> o_fault_n;
    endproperty
    property p_reset_values;
        $rose(i_rst_n) |-> o_clip_detect_enable && o_clip_window_select == 8'h14 && o_fault_n && o_warn_n
            && !o_parallel_bridge_source_flip && !o_overtemp_auto_recover && !o_sda_oe;
    endproperty
    // Writes land shortly after a bus clock fall
    property p_ctrl_hold;
        i_scl [*6] |-> $stable(o_clip_window_select) && $stable(o_clip_detect_enable)
            && $stable(o_parallel_bridge_source_flip) && $stable(o_overtemp_auto_recover);
    endproperty
    property p_sda_edge;
        ($rose(o_sda_oe) || $fell(o_sda_oe)) |-> !i_scl;
    endproperty

    a_clear_pulse: assert property (p_clear_pulse) else $error("clear pulse longer than one cycle");
    a_clear_drops_warn: assert property (p_clear_drops_warn) else $error("warn pin kept after clear");
    a_clip_warn: assert property (p_clip_warn) else $error("clip event not on warn pin");
    a_overtemp_fault: assert property (p_overtemp_fault) else $error("overtemp not on fault pin");
    a_auto_recover_quiet: assert property (p_auto_recover_quiet) else $error("fault pin low in recovery");
    a_reset_values: assert property (p_reset_values) else $error("wrong value after reset");
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed without a write");
    a_sda_edge: assert property (p_sda_edge) else $error("data line changed with bus clock high");
endmodule : amp_diag_regs_checker

bind amp_diag_clip_fault_regs amp_diag_regs_checker #(.NUM_CH(NUM_CH)) i_amp_diag_regs_checker (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_scl(i_scl), .o_sda_oe(o_sda_oe),
    .i_clip_detect(i_clip_detect), .i_current_limit_event(i_current_limit_event),
    .i_overtemp_shutdown(i_overtemp_shutdown), .o_clear_fault(o_clear_fault),
    .o_parallel_bridge_source_flip(o_parallel_bridge_source_flip),
    .o_overtemp_auto_recover(o_overtemp_auto_recover), .o_clip_detect_enable(o_clip_detect_enable),
    .o_clip_window_select(o_clip_window_select), .o_fault_n(o_fault_n), .o_warn_n(o_warn_n));
`default_nettype wire

// file: testbench/serial_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host_model #(
    parameter int unsigned HALF = 6
)(
    // Clock and bus
    input wire logic i_clock,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    initial
    begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    task automatic hp();
        repeat (HALF) @(negedge i_clock);
    endtask : hp
    // Hold two cycles after each fall before data may move
    task automatic pulse(output logic s);
        hp();
        o_scl = 1'b1;
        hp();
        s = i_sda;
        o_scl = 1'b0;
        repeat (2) @(negedge i_clock);
    endtask : pulse
    task automatic start();
        o_sda_low = 1'b0;
        hp();
        o_scl = 1'b1;
        hp();
        o_sda_low = 1'b1;
        hp();
        o_scl = 1'b0;
        hp();
    endtask : start
    task automatic stop();
        o_sda_low = 1'b1;
        hp();
        o_scl = 1'b1;
        hp();
        o_sda_low = 1'b0;
        hp();
    endtask : stop
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            o_sda_low = ~b[i];
            pulse(s);
        end
        o_sda_low = 1'b0;
        pulse(s);
        ack = ~s;
    endtask : send_byte
    // Leaves the line as the acknowledge left it; the following stop moves it
    task automatic recv_byte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            pulse(b[i]);
        o_sda_low = ~nack;
        pulse(s);
    endtask : recv_byte
    // A one in bit 7 of the fault control byte asks for a fault clear
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic k1, k2, k3;
        start();
        send_byte({dev, 1'b0}, k1);
        send_byte(a, k2);
        send_byte(d, k3);
        stop();
        ok = k1 & k2 & k3;
    endtask : write_reg
    task automatic read_reg(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d, output logic ok);
        logic k1, k2, k3;
        start();
        send_byte({dev, 1'b0}, k1);
        send_byte(a, k2);
        start();
        send_byte({dev, 1'b1}, k3);
        recv_byte(1'b1, d);
        stop();
        ok = k1 & k2 & k3;
    endtask : read_reg
endmodule : serial_host_model
`default_nettype wire

// file: testbench/amp_diag_clip_fault_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module amp_diag_clip_fault_regs_test;
    import amp_diag_pkg::*;
    logic clock, rst_n, scl, sda_low, sda, sda_out, sda_oe, diag_done, overtemp;
    logic clear_fault, flip, auto_rec, clip_en, fault_n, warn_n;
    diag_result_s diag_result;
    logic [3:0] clip, ilim;
    logic [7:0] window;
    int mismatches = 0, n_checks = 0, n_clear = 0;
    logic [7:0] ra [10] = '{8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h30};
    logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h14, 8'h00, 8'h00, 8'h00};
    // Open-drain data line with a pull-up
    assign sda = !(sda_low || (sda_oe && !sda_out));

    amp_diag_clip_fault_regs i_amp_diag_clip_fault_regs (
        .i_clock(clock), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
        .i_diag_done(diag_done), .i_diag_result(diag_result), .i_clip_detect(clip),
        .i_current_limit_event(ilim), .i_overtemp_shutdown(overtemp), .o_clear_fault(clear_fault),
        .o_parallel_bridge_source_flip(flip), .o_overtemp_auto_recover(auto_rec),
        .o_clip_detect_enable(clip_en), .o_clip_window_select(window), .o_fault_n(fault_n), .o_warn_n(warn_n));
    serial_host_model i_serial_host_model (.i_clock(clock), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock)
    begin
        if (clear_fault === 1'b1)
            n_clear++;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        i_serial_host_model.write_reg(DEFAULT_TARGET_ADDR, a, d, ok);
        check("write ack", {7'h00, ok}, 8'h01);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        i_serial_host_model.read_reg(DEFAULT_TARGET_ADDR, a, d, ok);
        check($sformatf("register %h", a), d, exp);
    endtask : rd
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results

    initial
    begin
        logic ok;
        logic [7:0] w;
        rst_n = 1'b0;
        diag_done = 1'b0;
        diag_result = '0;
        clip = 4'h0;
        ilim = 4'h0;
        overtemp = 1'b0;
        tick(5);
        rst_n = 1'b1;
        tick(4);
        check("window pin", window, 8'h14);
        check("pins", {fault_n, warn_n, clip_en, flip, auto_rec}, 8'h1C);
        for (int i = 0; i < 10; i++)
            rd(ra[i], rv[i]);
        $display("test reset values done");
        diag_result = {16'hA5C3, 16'h3C96};
        diag_done = 1'b1;
        tick(1);
        diag_done = 1'b0;
        diag_result = '0;
        rv[0:3] = '{8'hA5, 8'hC3, 8'h3C, 8'h96};
        for (int i = 0; i < 4; i++)
            rd(ra[i], rv[i]);
        // Read-only places ignore writes
        for (int i = 0; i < 9; i++)
            if (i < 4 || i > 6)
            begin
                wr(ra[i], 8'hFF);
                rd(ra[i], rv[i]);
            end
        $display("test diagnostic results done");
        wr(8'h21, 8'h68);
        rd(8'h21, 8'h68);
        check("flip and recover", {flip, auto_rec}, 8'h03);
        wr(8'h22, 8'h00);
        check("clip enable", clip_en, 8'h00);
        wr(8'h22, 8'hFF);
        rd(8'h22, 8'h01);
        // Listed codes: 0x00 to 0x0A, then 0x0E and 0x14
        for (int i = 0; i < 13; i++)
        begin
            w = (i < 11) ? 8'(i) : ((i == 11) ? 8'h0E : 8'h14);
            wr(8'h23, w);
            rd(8'h23, w);
            check("window pin", window, w);
        end
        $display("test controls done");
        ilim = 4'hA;
        tick(1);
        ilim = 4'h0;
        tick(3);
        check("masked warn", warn_n, 8'h01);
        rd(8'h25, 8'h0A);
        clip = 4'h5;
        overtemp = 1'b1;
        tick(1);
        clip = 4'h0;
        overtemp = 1'b0;
        tick(3);
        check("clip warn", warn_n, 8'h00);
        check("recovered fault", fault_n, 8'h01);
        rd(8'h24, 8'h05);
        wr(8'h21, 8'h80);
        tick(3);
        check("clear pulses", n_clear[7:0], 8'h01);
        rd(8'h24, 8'h00);
        rd(8'h25, 8'h00);
        rd(8'h21, 8'h00);
        check("warn after clear", warn_n, 8'h01);
        ilim = 4'h1;
        overtemp = 1'b1;
        tick(1);
        ilim = 4'h0;
        overtemp = 1'b0;
        tick(3);
        check("limit warn", warn_n, 8'h00);
        check("overtemp fault", fault_n, 8'h00);
        rd(8'h25, 8'h01);
        wr(8'h21, 8'h08);
        tick(3);
        check("fault released", fault_n, 8'h01);
        wr(8'h22, 8'h00);
        clip = 4'hF;
        tick(1);
        clip = 4'h0;
        rd(8'h24, 8'h00);
        $display("test events done");
        i_serial_host_model.write_reg(DEFAULT_TARGET_ADDR ^ 7'h01, 8'h23, 8'h00, ok);
        check("foreign ack", {7'h00, ok}, 8'h00);
        rd(8'h23, 8'h14);
        $display("test foreign address done");
        results();
    end

    initial
    begin
        #600000;
        mismatches++;
        $display("watchdog expired");
        results();
    end
endmodule : amp_diag_clip_fault_regs_test
`default_nettype wire
